// [design/serial_port.sv]
// four mode serial port with transmit fifo
`timescale 1ns/1ps
`default_nettype none
// Function
// - buffer write loads transmitter; buffer read returns separate receive byte
// - mode bits pick shift, 8-bit variable, 9-bit fixed, 9-bit variable
// - 8-bit mode with filtering: bad stop bit raises no receive flag
// - 9-bit modes with filtering: ninth bit 0 raises no receive flag
// - async receiver works only while rx_enable is set
// - 9-bit modes send tx_ninth_bit as ninth data bit
// - rx_ninth_bit takes ninth bit, or stop bit in 8-bit mode
// - transmit flag set at eighth bit end or stop start; software clears
// - receive flag set at eighth bit end or mid stop; software clears
// - shift mode: data on input line, clock on output line, lsb first
// - shift mode receive starts when rx_enable is 1 and flag is 0
// - 8-bit frame: low start, eight data lsb first, high stop
// - variable rates come from timer overflow pulses, per direction
// - 8-bit mode loads a 1 as ninth bit, the stop bit
// - async receive begins on falling edge, start bit discarded
// - final shift latches byte, ninth bit and flag only when allowed
// - fixed 9-bit rate is core clock over 64, or 32 doubled
// - 9-bit frame: start, eight data, ninth bit, stop: eleven bits
// - 9-bit transmit starts shifting at next bit-rate tick
// - variable 9-bit mode equals fixed mode except timing source
// - buffer write accepted by the fifo starts transmit, a write while full is dropped; async receive needs rx_enable
// - receiver double-buffered: shift register apart from read buffer
// - timer 2 timing: sixteen overflows per bit
// - in variable modes, clock-from-timer-2 selects pick timer 2, else timer 1

module serial_tx_fifo
   import serial_port_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd_ptr;
      logic [AW-1:0]               wr_ptr;
      logic [AW:0]                 count;
   } fifo_state_t;

   fifo_state_t st_ff;
   fifo_state_t nxt_st;
   logic        push;
   logic        pop;

   // pointer advance with wrap, depth need not be a power of two
   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      return (p == LAST_PTR) ? '0 : p + 1'b1;
   endfunction

   // handshakes
   assign in_ready  = (st_ff.count != FULL_CNT);
   assign out_valid = (st_ff.count != '0);
   assign out_data  = st_ff.mem[st_ff.rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // next state
   always_comb
   begin
      nxt_st = st_ff;
      if (push)
      begin
         nxt_st.mem[st_ff.wr_ptr] = in_data;
         nxt_st.wr_ptr            = next_ptr(st_ff.wr_ptr);
      end
      if (pop)
      begin
         nxt_st.rd_ptr = next_ptr(st_ff.rd_ptr);
      end
      nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
endmodule // serial_tx_fifo

module serial_port
   import serial_port_pkg::*;
#(
   parameter int TX_FIFO_DEPTH = 8
)
(
   input  wire logic       CORE_CLK,
   input  wire logic       RESETN,
   input  wire sfr_req_t   SFR_REQ,
   output logic [7:0]      SFR_RDATA,
   output logic            TX_READY,
   input  wire logic       BAUD_DOUBLE,
   input  wire logic       TX_CLK_FROM_T2,
   input  wire logic       RX_CLK_FROM_T2,
   input  wire logic       T1_OVF,
   input  wire logic       T2_OVF,
   input  wire logic       SERIAL_IN_LINE,
   output logic            SERIAL_IN_DRIVE,
   output logic            SERIAL_IN_OE_N,
   output logic            SERIAL_OUT_LINE
);
   typedef enum logic [3:0]
   {
      TX_IDLE = 4'b0001,
      TX_WAIT = 4'b0010,
      TX_RUN  = 4'b0100,
      TX_SH0  = 4'b1000
   } tx_state_t;

   typedef enum logic [2:0]
   {
      RX_IDLE  = 3'b001,
      RX_START = 3'b010,
      RX_DATA  = 3'b100
   } rx_state_t;

   typedef struct packed
   {
      logic        in_s1;
      logic        in_s2;
      logic        in_s3;
      ctrl_t       ctrl;
      logic [7:0]  rx_buf;
      logic [7:0]  rdata;
      tx_state_t   tx_st;
      logic [10:0] tx_sh;
      logic [3:0]  tx_bits;
      logic [3:0]  tx_div;
      logic        m0_rx;
      logic        m0_ph;
      logic        txd;
      logic        drv;
      logic        oe_n;
      rx_state_t   rx_st;
      logic [3:0]  rx_div;
      logic [3:0]  rx_bits;
      logic [9:0]  rx_sh;
      logic        t1_half;
      logic [1:0]  fix_div;
   } core_state_t;

   core_state_t st_ff;
   core_state_t nxt_st;
   logic [1:0]  mode;
   logic        nine;
   logic        fix_tick;
   logic        t1_tick;
   logic        tx_tick;
   logic        rx_tick;
   logic        tx_bit;
   logic        rx_fall;
   logic [3:0]  tx_last;
   logic [3:0]  rx_last;
   logic        fifo_valid;
   logic        fifo_pop;
   logic [7:0]  fifo_data;
   logic        fifo_ready;
   logic [9:0]  rx_new;
   logic        rx_bit9;
   logic        m0_in;
   logic        set_ti;
   logic        set_ri;

   // one decoder for both read and write side of the port
   function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
      return a == t;
   endfunction

   // 16x sample enable for one direction
   function automatic logic pick_tick(input logic [1:0] m,
                                      input logic       use_t2,
                                      input logic       fix,
                                      input logic       t1,
                                      input logic       t2);
      if (m == MODE_9FIX)
         return fix;
      return use_t2 ? t2 : t1;
   endfunction

   // mode decode and rate enables
   assign mode     = {st_ff.ctrl.mode_sel_hi, st_ff.ctrl.mode_sel_lo};
   assign nine     = mode[1];
   assign tx_last  = nine ? TX_LAST_9 : TX_LAST_8;
   assign rx_last  = nine ? RX_LAST_9 : RX_LAST_8;
   assign fix_tick = st_ff.fix_div ==
                     (BAUD_DOUBLE ? FIX_FAST_LIM : FIX_SLOW_LIM);
   // timer 1 runs at 32 overflows per bit unless doubled
   assign t1_tick  = T1_OVF & (BAUD_DOUBLE | st_ff.t1_half);
   assign tx_tick  = pick_tick(mode, TX_CLK_FROM_T2, fix_tick, t1_tick,
                               T2_OVF);
   assign rx_tick  = pick_tick(mode, RX_CLK_FROM_T2, fix_tick, t1_tick,
                               T2_OVF);
   assign tx_bit   = tx_tick & (st_ff.tx_div == SAMPLE_LAST);
   // edge seen on synchronised copies only
   assign rx_fall  = st_ff.in_s3 & ~st_ff.in_s2;
   assign rx_new   = {st_ff.in_s2, st_ff.rx_sh[9:1]};
   assign rx_bit9  = nine ? rx_new[8] : rx_new[9];
   assign m0_in    = st_ff.m0_rx & st_ff.in_s2;

   // buffer writes queue here so software may write ahead
   serial_tx_fifo
   #(
      .WIDTH (8),
      .DEPTH (TX_FIFO_DEPTH)
   )
   u_tx_fifo
   (
      .clk       (CORE_CLK),
      .resetn    (RESETN),
      .in_valid  (SFR_REQ.wr & hit(SFR_REQ.addr, BUF_ADDR)),
      .in_ready  (fifo_ready),
      .in_data   (SFR_REQ.wdata),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // next state of the whole port
   always_comb
   begin
      nxt_st   = st_ff;
      set_ti   = 1'b0;
      set_ri   = 1'b0;
      fifo_pop = 1'b0;

      // two stage synchroniser, stage three only for edge detect
      nxt_st.in_s1 = SERIAL_IN_LINE;
      nxt_st.in_s2 = st_ff.in_s1;
      nxt_st.in_s3 = st_ff.in_s2;

      // rate dividers
      nxt_st.fix_div = fix_tick ? 2'h0 : st_ff.fix_div + 2'h1;
      if (T1_OVF)
         nxt_st.t1_half = ~st_ff.t1_half;
      if (tx_tick)
         nxt_st.tx_div = st_ff.tx_div + 4'h1;

      // register port; receive byte and control read back
      if (SFR_REQ.rd)
      begin
         if (hit(SFR_REQ.addr, BUF_ADDR))
            nxt_st.rdata = st_ff.rx_buf;
         else if (hit(SFR_REQ.addr, CTRL_ADDR))
            nxt_st.rdata = st_ff.ctrl;
         else
            nxt_st.rdata = RD_UNMAPPED;
      end
      if (SFR_REQ.wr && hit(SFR_REQ.addr, CTRL_ADDR))
         nxt_st.ctrl = ctrl_t'(SFR_REQ.wdata);

      // transmitter, also drives the shift clock in mode 0
      case (st_ff.tx_st)
         TX_IDLE:
         begin
            nxt_st.txd  = 1'b1;
            nxt_st.drv  = 1'b1;
            nxt_st.oe_n = 1'b1;
            nxt_st.tx_bits = 4'h0;
            nxt_st.m0_ph   = 1'b0;
            if (fifo_valid)
            begin
               fifo_pop     = 1'b1;
               nxt_st.m0_rx = 1'b0;
               // ninth slot is the stop bit in 8-bit mode
               nxt_st.tx_sh = {1'b1,
                               nine ? st_ff.ctrl.tx_ninth_bit : 1'b1,
                               fifo_data, 1'b0};
               if (mode == MODE_SHIFT)
               begin
                  nxt_st.tx_sh[7:0] = fifo_data;
                  nxt_st.txd        = 1'b0;
                  nxt_st.drv        = fifo_data[0];
                  nxt_st.oe_n       = 1'b0;
                  nxt_st.tx_st      = TX_SH0;
               end
               else
                  nxt_st.tx_st = TX_WAIT;
            end
            else if (mode == MODE_SHIFT && st_ff.ctrl.rx_enable &&
                     !st_ff.ctrl.rx_done_flag)
            begin
               nxt_st.m0_rx = 1'b1;
               nxt_st.txd   = 1'b0;
               nxt_st.tx_st = TX_SH0;
            end
         end
         TX_WAIT:
         begin
            // hold off until the next bit-rate tick
            if (tx_bit)
            begin
               nxt_st.txd   = st_ff.tx_sh[0];
               nxt_st.tx_st = TX_RUN;
            end
         end
         TX_RUN:
         begin
            if (tx_bit)
            begin
               if (st_ff.tx_bits == tx_last)
               begin
                  nxt_st.txd   = 1'b1;
                  nxt_st.tx_st = TX_IDLE;
               end
               else
               begin
                  nxt_st.tx_sh   = {1'b1, st_ff.tx_sh[10:1]};
                  nxt_st.txd     = st_ff.tx_sh[1];
                  nxt_st.tx_bits = st_ff.tx_bits + 4'h1;
                  if (st_ff.tx_bits + 4'h1 == tx_last)
                     set_ti = 1'b1;
               end
            end
         end
         TX_SH0:
         begin
            // one core cycle per half period: clock low, then high
            nxt_st.m0_ph = ~st_ff.m0_ph;
            if (!st_ff.m0_ph)
               nxt_st.txd = 1'b1;
            else
            begin
               nxt_st.tx_sh[7:0] = {m0_in, st_ff.tx_sh[7:1]};
               nxt_st.tx_bits    = st_ff.tx_bits + 4'h1;
               if (st_ff.tx_bits == M0_LAST)
               begin
                  nxt_st.tx_st = TX_IDLE;
                  nxt_st.oe_n  = 1'b1;
                  if (st_ff.m0_rx)
                  begin
                     nxt_st.rx_buf = {m0_in, st_ff.tx_sh[7:1]};
                     set_ri        = 1'b1;
                  end
                  else
                     set_ti = 1'b1;
               end
               else
               begin
                  nxt_st.txd = 1'b0;
                  nxt_st.drv = st_ff.tx_sh[1];
               end
            end
         end
         default:
         begin
            nxt_st.tx_st = TX_IDLE;
         end
      endcase

      // asynchronous receiver; its shift register is the second buffer
      case (st_ff.rx_st)
         RX_IDLE:
         begin
            nxt_st.rx_div  = 4'h0;
            nxt_st.rx_bits = 4'h0;
            if (mode != MODE_SHIFT && st_ff.ctrl.rx_enable && rx_fall)
               nxt_st.rx_st = RX_START;
         end
         RX_START:
         begin
            if (!st_ff.ctrl.rx_enable || mode == MODE_SHIFT)
               nxt_st.rx_st = RX_IDLE;
            else if (rx_tick)
            begin
               nxt_st.rx_div = st_ff.rx_div + 4'h1;
               if (st_ff.rx_div == SAMPLE_MID)
               begin
                  // a glitch shorter than half a bit is ignored
                  nxt_st.rx_div = 4'h0;
                  nxt_st.rx_st  = st_ff.in_s2 ? RX_IDLE : RX_DATA;
               end
            end
         end
         RX_DATA:
         begin
            if (!st_ff.ctrl.rx_enable || mode == MODE_SHIFT)
               nxt_st.rx_st = RX_IDLE;
            else if (rx_tick)
            begin
               nxt_st.rx_div = st_ff.rx_div + 4'h1;
               if (st_ff.rx_div == SAMPLE_LAST)
               begin
                  nxt_st.rx_sh   = rx_new;
                  nxt_st.rx_bits = st_ff.rx_bits + 4'h1;
                  if (st_ff.rx_bits == rx_last)
                  begin
                     nxt_st.rx_st = RX_IDLE;
                     // frame dropped when flag pending or filtered
                     if (!st_ff.ctrl.rx_done_flag &&
                         (!st_ff.ctrl.multiproc_enable || rx_bit9))
                     begin
                        nxt_st.rx_buf = nine ? rx_new[7:0]
                                             : rx_new[8:1];
                        nxt_st.ctrl.rx_ninth_bit = rx_bit9;
                        set_ri = 1'b1;
                     end
                  end
               end
            end
         end
         default:
         begin
            nxt_st.rx_st = RX_IDLE;
         end
      endcase

      // hardware set beats a software clear in the same cycle
      if (set_ti)
         nxt_st.ctrl.tx_done_flag = 1'b1;
      if (set_ri)
         nxt_st.ctrl.rx_done_flag = 1'b1;
   end

   // state register; line idles high after reset
   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_ff        <= '0;
         st_ff.in_s1  <= 1'b1;
         st_ff.in_s2  <= 1'b1;
         st_ff.in_s3  <= 1'b1;
         st_ff.ctrl   <= CTRL_RST;
         st_ff.rx_buf <= BUF_RST;
         st_ff.tx_st  <= TX_IDLE;
         st_ff.rx_st  <= RX_IDLE;
         st_ff.txd    <= 1'b1;
         st_ff.drv    <= 1'b1;
         st_ff.oe_n   <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   // outputs
   assign SFR_RDATA       = st_ff.rdata;
   assign TX_READY        = fifo_ready;
   assign SERIAL_OUT_LINE = st_ff.txd;
   assign SERIAL_IN_DRIVE = st_ff.drv;
   assign SERIAL_IN_OE_N  = st_ff.oe_n;
endmodule // serial_port
`default_nettype wire

// [design/serial_port_pkg.sv]
// shared constants and types for the four mode serial port
package serial_port_pkg;

   // register map of the special function register port
   localparam logic [7:0] CTRL_ADDR = 8'h98;
   localparam logic [7:0] BUF_ADDR  = 8'h99;
   localparam logic [7:0] BUF_RST   = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // operating modes, value of {mode_sel_hi, mode_sel_lo}
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_8VAR  = 2'h1;
   localparam logic [1:0] MODE_9FIX  = 2'h2;
   localparam logic [1:0] MODE_9VAR  = 2'h3;

   // bit timing: the async engines sample at 16x the bit rate
   localparam int SAMPLES_PER_BIT = 16;
   localparam int FIX_DIV_SLOW    = 64;
   localparam int FIX_DIV_FAST    = 32;
   localparam logic [1:0] FIX_SLOW_LIM =
      2'(FIX_DIV_SLOW / SAMPLES_PER_BIT - 1);
   localparam logic [1:0] FIX_FAST_LIM =
      2'(FIX_DIV_FAST / SAMPLES_PER_BIT - 1);
   localparam logic [3:0] SAMPLE_MID  = 4'(SAMPLES_PER_BIT / 2 - 1);
   localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLES_PER_BIT - 1);

   // frame lengths as index of the last bit (tx: start bit is index 0; rx and shift: first data bit is index 0)
   localparam logic [3:0] TX_LAST_8 = 4'h9;
   localparam logic [3:0] TX_LAST_9 = 4'ha;
   localparam logic [3:0] RX_LAST_8 = 4'h8;
   localparam logic [3:0] RX_LAST_9 = 4'h9;
   localparam logic [3:0] M0_LAST   = 4'h7;

   // control and status register, msb first
   typedef struct packed
   {
      logic mode_sel_hi;
      logic mode_sel_lo;
      logic multiproc_enable;
      logic rx_enable;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = ctrl_t'(8'h00);

   // one access on the special function register port
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

endpackage

// [dv/serial_peer.sv]
// remote serial device: frame decoder, frame sender, shift peripheral
`timescale 1ns/1ps
`default_nettype none
module serial_peer
(
   input  wire logic       clk,
   input  wire logic       async_on,
   input  wire logic [7:0] bit_cyc,
   input  wire logic [3:0] nb,
   input  wire logic       sout,
   input  wire logic       oe_n,
   input  wire logic       drive,
   output logic            rxd,
   output logic [10:0]     got,
   output logic [7:0]      n_frm,
   output logic [7:0]      m0_byte,
   output logic [7:0]      n_m0
);
   logic       cq = 1'b1;
   logic       oq = 1'b1;
   logic [7:0] sh = 8'h00;

   // async decoder, mid-bit samples; never overshoots past mid-stop
   initial
   begin : dec
      logic        sq;
      logic [10:0] w;
      rxd = 1'b1;
      got = '1;
      n_frm = 8'h00;
      sq = 1'b1;
      forever
      begin
         @(posedge clk);
         if (async_on && sq && !sout)
         begin
            w = '1;
            repeat (bit_cyc / 2) @(posedge clk);
            for (int k = 0; k < nb; k++)
            begin
               if (k != 0)
                  repeat (bit_cyc) @(posedge clk);
               w[k] = sout;
            end
            got = w;
            n_frm = n_frm + 8'h01;
         end
         sq = sout;
      end
   end

   // one frame, start bit in bit 0, then idle high
   task automatic send(input logic [10:0] frm);
      for (int k = 0; k < nb; k++)
      begin
         rxd <= frm[k];
         repeat (bit_cyc) @(posedge clk);
      end
      rxd <= 1'b1;
   endtask

   // shift peripheral takes data on the rising shift clock
   initial
   begin
      m0_byte = 8'h00;
      n_m0 = 8'h00;
   end
   always @(posedge clk)
   begin
      cq <= sout;
      oq <= oe_n;
      if (!oe_n && sout && !cq)
         sh <= {drive, sh[7:1]};
      if (oe_n && !oq)
      begin
         m0_byte <= sh;
         n_m0 <= n_m0 + 8'h01;
      end
   end
endmodule // serial_peer
`default_nettype wire

// [dv/serial_port_assertions.sv]
// assertion checker on the serial port pins and register port
`timescale 1ns/1ps
`default_nettype none
module serial_port_chk
   import serial_port_pkg::*;
(
   input wire logic       CORE_CLK,
   input wire logic       RESETN,
   input wire sfr_req_t   SFR_REQ,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       TX_READY,
   input wire logic       SERIAL_IN_DRIVE,
   input wire logic       SERIAL_IN_OE_N,
   input wire logic       SERIAL_OUT_LINE
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);

   // lines idle and fifo open on the first edge after reset
   property p_rst_idle;
      $rose(RESETN) |-> SERIAL_OUT_LINE && SERIAL_IN_OE_N && TX_READY;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("lines not idle after reset");

   // unmapped reads answer zero one cycle later
   property p_unmapped;
      SFR_REQ.rd && SFR_REQ.addr != CTRL_ADDR && SFR_REQ.addr != BUF_ADDR
         |=> SFR_RDATA == RD_UNMAPPED;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");

   // read data holds between reads
   property p_rdata_hold;
      !SFR_REQ.rd |=> $stable(SFR_RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");

   // mode, filter, enable and ninth bit are software-only bits
   property p_ctl_readback;
      SFR_REQ.wr && SFR_REQ.addr == CTRL_ADDR ##1 !SFR_REQ.wr
         ##1 SFR_REQ.rd && SFR_REQ.addr == CTRL_ADDR
         |=> SFR_RDATA[7:3] == $past(SFR_REQ.wdata[7:3], 3);
   endproperty
   a_ctl_readback: assert property (p_ctl_readback)
      else $error("control bits read back wrong");

   // shift clock low phase is a single cycle
   property p_clk_low_one;
      !SERIAL_IN_OE_N && !SERIAL_OUT_LINE |=> SERIAL_OUT_LINE;
   endproperty
   a_clk_low_one: assert property (p_clk_low_one)
      else $error("shift clock low too long");

   // shift frame opens with the clock low
   property p_clk_first_low;
      $fell(SERIAL_IN_OE_N) |-> !SERIAL_OUT_LINE;
   endproperty
   a_clk_first_low: assert property (p_clk_first_low)
      else $error("shift frame began with clock high");

   // eight bits of two cycles each, then the pin is released
   property p_shift_len;
      $fell(SERIAL_IN_OE_N) |-> ##16 $rose(SERIAL_IN_OE_N);
   endproperty
   a_shift_len: assert property (p_shift_len)
      else $error("shift frame length wrong");

   // data must not move while the peripheral samples on clock high
   property p_drive_stable;
      !SERIAL_IN_OE_N && SERIAL_OUT_LINE |-> $stable(SERIAL_IN_DRIVE);
   endproperty
   a_drive_stable: assert property (p_drive_stable)
      else $error("shift data moved in clock high");
endmodule // serial_port_chk

bind serial_port serial_port_chk chk_u
(
   .CORE_CLK        (CORE_CLK),
   .RESETN          (RESETN),
   .SFR_REQ         (SFR_REQ),
   .SFR_RDATA       (SFR_RDATA),
   .TX_READY        (TX_READY),
   .SERIAL_IN_DRIVE (SERIAL_IN_DRIVE),
   .SERIAL_IN_OE_N  (SERIAL_IN_OE_N),
   .SERIAL_OUT_LINE (SERIAL_OUT_LINE)
);
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the four mode serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import serial_port_pkg::*;
;
   logic        core_clk;
   logic        resetn;
   sfr_req_t    sfr_req;
   logic [7:0]  sfr_rdata;
   logic        tx_ready;
   logic        baud_double;
   logic        tx_t2;
   logic        rx_t2;
   logic        t1_ovf = 1'b0;
   logic        t2_ovf = 1'b0;
   logic        in_drive;
   logic        in_oe_n;
   logic        out_line;
   logic        peer_rxd;
   wire logic   in_line;
   logic        async_on = 1'b0;
   logic [7:0]  bit_cyc = 8'h20;
   logic [3:0]  nb = 4'ha;
   logic [10:0] got;
   logic [7:0]  n_frm;
   logic [7:0]  m0_byte;
   logic [7:0]  n_m0;
   logic [31:0] seed = 32'h21;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;

   // pin seen by the receiver: the port's own drive wins while in_oe_n is low (shift transmit)
   assign in_line = in_oe_n ? peer_rxd : in_drive;

   serial_port #(.TX_FIFO_DEPTH(8)) dut_u
   (
      .CORE_CLK        (core_clk),
      .RESETN          (resetn),
      .SFR_REQ         (sfr_req),
      .SFR_RDATA       (sfr_rdata),
      .TX_READY        (tx_ready),
      .BAUD_DOUBLE     (baud_double),
      .TX_CLK_FROM_T2  (tx_t2),
      .RX_CLK_FROM_T2  (rx_t2),
      .T1_OVF          (t1_ovf),
      .T2_OVF          (t2_ovf),
      .SERIAL_IN_LINE  (in_line),
      .SERIAL_IN_DRIVE (in_drive),
      .SERIAL_IN_OE_N  (in_oe_n),
      .SERIAL_OUT_LINE (out_line)
   );

   serial_peer peer_u
   (
      .clk      (core_clk),
      .async_on (async_on),
      .bit_cyc  (bit_cyc),
      .nb       (nb),
      .sout     (out_line),
      .oe_n     (in_oe_n),
      .drive    (in_drive),
      .rxd      (peer_rxd),
      .got      (got),
      .n_frm    (n_frm),
      .m0_byte  (m0_byte),
      .n_m0     (n_m0)
   );

   // 50 ns clock
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // overflow pulses every second cycle, so 32 cycles per bit
   always @(posedge core_clk)
   begin
      t1_ovf <= ~t1_ovf;
      t2_ovf <= t1_ovf;
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         miscompares++;
         results();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // start bit in bit 0, stop bit above the ninth
   function automatic logic [10:0] frame(logic [7:0] d, logic n9);
      return {1'b1, n9, d, 1'b0};
   endfunction

   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic results();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // one register access, a cycle of rest after it
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge core_clk);
      sfr_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      sfr_req <= '0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk({3'b000, sfr_rdata}, {3'b000, e});
   endtask

   task automatic wait_cnt(input logic m0, input logic [7:0] n);
      for (int k = 0; k < 5000 && (m0 ? n_m0 : n_frm) != n; k++)
         @(posedge core_clk);
   endtask

   task automatic rx_frame(input logic [7:0] d, input logic n9);
      @(posedge core_clk);
      peer_u.send(frame(d, n9));
      repeat (8) @(posedge core_clk);
   endtask

   // main sequence
   initial
   begin : main
      logic [1:0] mode;
      logic [7:0] sc;
      logic [7:0] d;
      logic [7:0] n0;
      logic       t8;
      resetn = 1'b0;
      sfr_req = '0;
      baud_double = 1'b1;
      tx_t2 = 1'b0;
      rx_t2 = 1'b0;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      rd(CTRL_ADDR, 8'h00);
      rd(8'h55, RD_UNMAPPED);
      async_on = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         mode = (i == 0) ? MODE_8VAR : (i == 3) ? MODE_9VAR : MODE_9FIX;
         baud_double <= (i != 1);
         tx_t2 <= i[0];
         rx_t2 <= !i[0];
         bit_cyc = (i == 1) ? 8'h40 : 8'h20;
         nb = (mode == MODE_8VAR) ? 4'ha : 4'hb;
         d = 8'(rnd());
         t8 = ^d;
         sc = {mode, 2'b01, t8, 3'b000};
         acc(1'b1, CTRL_ADDR, sc);
         rd(CTRL_ADDR, sc);
         n0 = n_frm;
         acc(1'b1, BUF_ADDR, d);
         wait_cnt(1'b0, n0 + 8'h01);
         chk(got, frame(d, (mode == MODE_8VAR) | t8));
         rd(CTRL_ADDR, sc | 8'h02);
         rx_frame(~d, 1'b1);
         rd(BUF_ADDR, ~d);
         rd(CTRL_ADDR, sc | 8'h07);
         rx_frame(d, 1'b1);
         rd(BUF_ADDR, ~d);
         acc(1'b1, CTRL_ADDR, sc | 8'h20);
         rx_frame(d, 1'b0);
         rd(CTRL_ADDR, sc | 8'h20);
         rx_frame(d, 1'b1);
         rd(BUF_ADDR, d);
         rd(CTRL_ADDR, sc | 8'h25);
         acc(1'b1, CTRL_ADDR, sc & 8'hef);
         rx_frame(~d, 1'b1);
         rd(CTRL_ADDR, sc & 8'hef);
      end
      // shift register mode, receiver off
      async_on = 1'b0;
      acc(1'b1, CTRL_ADDR, 8'h00);
      d = 8'(rnd());
      n0 = n_m0;
      acc(1'b1, BUF_ADDR, d);
      wait_cnt(1'b1, n0 + 8'h01);
      chk({3'b000, m0_byte}, {3'b000, d});
      rd(CTRL_ADDR, 8'h02);
      // line idles high, so a shift receive collects all ones
      acc(1'b1, CTRL_ADDR, 8'h10);
      repeat (24) @(posedge core_clk);
      rd(CTRL_ADDR, 8'h11);
      rd(BUF_ADDR, 8'hff);
      // fill the fifo past full; the refused write must never appear
      async_on = 1'b1;
      bit_cyc = 8'h20;
      nb = 4'ha;
      tx_t2 <= 1'b0;
      baud_double <= 1'b1;
      acc(1'b1, CTRL_ADDR, 8'h40);
      n0 = n_frm;
      for (int k = 0; k < 10; k++)
      begin
         acc(1'b1, BUF_ADDR, 8'(k));
         chk({10'h000, tx_ready}, {10'h000, k < 8});
      end
      wait_cnt(1'b0, n0 + 8'h09);
      chk(got, frame(8'h08, 1'b1));
      repeat (800) @(posedge core_clk);
      chk({3'b000, n_frm}, {3'b000, n0 + 8'h09});
      results();
   end
endmodule // tb_top
`default_nettype wire
